// file: pkg/pdc_defines.svh
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

`define PDC_DECADES        6
`define PDC_CNT_W          24
`define PDC_COUNT_ZERO     24'h000000
`define PDC_DIGIT_MAX      4'h9
`define PDC_DIGIT_ZERO     4'h0
`define PDC_LSD_IDX        3'h0
`define PDC_MSD_IDX        3'h5
`define PDC_DSEL_LSD       6'h01
`define PDC_DSEL_MSD       6'h20

`define PDC_OFF_CTRL       8'h00
`define PDC_OFF_COUNT      8'h04
`define PDC_OFF_FLAGS      8'h08
`define PDC_OFF_PRESET     8'h0C
`define PDC_OFF_PRESIG     8'h10
`define PDC_OFF_MAIN       8'h14
`define PDC_OFF_LATCH      8'h18

`define PDC_CTRL_W         12
`define PDC_CTRL_RST       12'h004
`define PDC_B_UP           0
`define PDC_B_INHIBIT      1
`define PDC_B_XFER         2
`define PDC_B_RESET        3
`define PDC_B_NO_AUTO_RST  4
`define PDC_B_PRESET       5
`define PDC_B_NO_AUTO_PRE  6
`define PDC_F_STORE_LO     7
`define PDC_F_STORE_HI     8
`define PDC_F_DIV_LO       9
`define PDC_F_DIV_HI       10
`define PDC_B_LAMP         11

`define PDC_FL_MAIN        0
`define PDC_FL_PRE         1
`define PDC_FL_ZERO        2
`define PDC_FL_DSEL_LO     4
`define PDC_FL_DSEL_HI     9
`define PDC_FL_STATE_LO    10
`define PDC_FL_STATE_HI    11

`define PDC_DIVSEL_5       2'h0
`define PDC_DIVSEL_6       2'h1
`define PDC_DIVSEL_1       2'h3
`define PDC_DIV5_LAST      3'h4
`define PDC_DIV6_LAST      3'h5
`define PDC_DIV1_LAST      3'h0

`define PDC_CLK_MHZ        125
`define PDC_MAIN_PULSE_NS  2500
`define PDC_ZERO_PULSE_NS  1500
`define PDC_MAIN_PULSE_CYC ((`PDC_MAIN_PULSE_NS * `PDC_CLK_MHZ + 999) / 1000)
`define PDC_ZERO_PULSE_CYC ((`PDC_ZERO_PULSE_NS * `PDC_CLK_MHZ + 999) / 1000)
`define PDC_TMR_W          9

`define PDC_SEG_ALL        7'h7F
`define PDC_SEG_OFF        7'h00

`endif

// file: pkg/pdc_pkg.sv
package pdc_pkg;

  typedef enum logic [1:0]
  {
    PDC_RUN      = 2'h0,
    PDC_HOLD_RST = 2'h1,
    PDC_HOLD_PRE = 2'h3
  } pdc_cnt_state_t;

  // gray sequence from most to least significant digit
  typedef enum logic [2:0]
  {
    PDC_SCAN_D5 = 3'h0,
    PDC_SCAN_D4 = 3'h1,
    PDC_SCAN_D3 = 3'h3,
    PDC_SCAN_D2 = 3'h2,
    PDC_SCAN_D1 = 3'h6,
    PDC_SCAN_D0 = 3'h7
  } pdc_scan_t;

  typedef enum logic [1:0]
  {
    PDC_SEL_NONE   = 2'h0,
    PDC_SEL_PRESIG = 2'h1,
    PDC_SEL_MAIN   = 2'h2,
    PDC_SEL_PRESET = 2'h3
  } pdc_store_sel_t;

endpackage : pdc_pkg

// file: verification/pdc_counter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_counter_sva (
  input wire logic        ref_clk,  // clock
  input wire logic        rst,      // reset
  input wire logic        scanClk,  // scan pin
  input wire logic        unblank,  // override pin
  input wire logic        psel,     // apb
  input wire logic        penable,  // apb
  input wire logic        pwrite,   // apb
  input wire logic [7:0]  paddr,    // apb
  input wire logic [31:0] pwdata,   // apb
  input wire logic [31:0] prdata,   // apb
  input wire logic        pready,   // apb
  input wire logic        zeroFlag, // zero flag
  input wire logic [5:0]  digitSel, // digit select
  input wire logic [3:0]  bcdOut,   // bcd digit
  input wire logic [6:0]  segOut    // segments
);
  logic [11:0] ctrlCopy;
  logic        rdCount;

  // control is internal, so keep a copy from the bus traffic
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      ctrlCopy <= 12'h004;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      ctrlCopy <= pwdata[11:0];

  assign rdCount = psel && penable && !pwrite && paddr == 8'h04;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sel_onehot_a : assert property ($onehot(digitSel))
    else $error("digit select not one-hot");
  scan_step_a : assert property ($rose(scanClk) |=> digitSel ==
    ($past(digitSel) == 6'h01 ? 6'h20 : $past(digitSel) >> 1))
    else $error("scan out of order");
  sel_hold_a : assert property (!$rose(scanClk) |=> $stable(digitSel))
    else $error("digit select moved without scan edge");
  bcd_hold_a : assert property (!$rose(scanClk) |=> $stable(bcdOut))
    else $error("bcd output moved within digit period");
  lsd_shown_a : assert property ($past(digitSel) == 6'h01 && digitSel == 6'h01 |-> segOut != 7'h00)
    else $error("least significant digit blanked");
  unblank_on_a : assert property ($past(unblank) && $stable(digitSel) |-> segOut != 7'h00)
    else $error("override did not unblank digit");
  lamp_all_a : assert property (ctrlCopy[11] && $past(ctrlCopy[11]) |-> segOut == 7'h7F)
    else $error("lamp test not all segments");
  reset_zero_a : assert property (rdCount && ctrlCopy[3] && $past(ctrlCopy[3]) |-> prdata[23:0] == 24'h000000)
    else $error("count not zero under reset");
  zero_flag_a : assert property (rdCount |=> zeroFlag == ($past(prdata[23:0]) == 24'h000000))
    else $error("zero flag disagrees with count");

  cover property ($rose(scanClk) && digitSel == 6'h01);
  cover property (rdCount && zeroFlag);
  cover property (ctrlCopy[11] && segOut == 7'h7F);
endmodule : pdc_counter_sva

bind pdc_counter pdc_counter_sva chk_u (
  .ref_clk(ref_clk), .rst(rst), .scanClk(scanClk), .unblank(unblank), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .zeroFlag(zeroFlag), .digitSel(digitSel), .bcdOut(bcdOut), .segOut(segOut)
);
`default_nettype wire

// file: verification/pdc_counter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    samplesChecked++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); \
    end \
  end

module pdc_counter_tb_top;
  localparam logic [31:0] B = 32'h0000_0054; // transfer on, automatic actions off
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        countIn = 1'b0;
  logic        scanClk = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [5:0]  unblankMask = 6'h00;
  logic [23:0] setting = 24'h0;
  logic [31:0] prdata, rdData;
  logic        pready, pslverr, errSeen, mainFlag, preFlag, zeroFlag, unblank;
  logic [3:0]  bcdIn, bcdOut;
  logic [5:0]  digitSel;
  logic [6:0]  segOut;
  int          mismatches = 0;
  int          samplesChecked = 0;

  pdc_counter dut_u (
    .ref_clk(ref_clk), .rst(rst), .countIn(countIn), .scanClk(scanClk), .bcdIn(bcdIn),
    .unblank(unblank), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mainFlag(mainFlag),
    .preFlag(preFlag), .zeroFlag(zeroFlag), .digitSel(digitSel), .bcdOut(bcdOut), .segOut(segOut)
  );
  pdc_panel_model panel_u (
    .digitSel(digitSel), .setting(setting), .unblankMask(unblankMask), .bcdIn(bcdIn), .unblank(unblank)
  );

  always #4 ref_clk = ~ref_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge ref_clk);
    if (n == 20)
    begin
      mismatches++;
      printVerdict();
    end
    rdData = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cnt(input int n);
    repeat (n)
    begin
      countIn <= 1'b1;
      cyc(2);
      countIn <= 1'b0;
      cyc(2);
    end
  endtask : cnt

  task automatic scan(input int n);
    repeat (n)
    begin
      scanClk <= 1'b1;
      cyc(3);
      scanClk <= 1'b0;
      cyc(3);
    end
  endtask : scan

  task automatic tRegs;
    apb(8'h00, 1'b0, 32'h0);
    `CHK(rdData, 32'h0000_0004)
    apb(8'h04, 1'b1, 32'h0000_0099);
    apb(8'h1C, 1'b1, 32'h0000_0001);
    `CHK(errSeen, 1'b1)
    apb(8'h00, 1'b1, B);
    apb(8'h04, 1'b0, 32'h0);
    `CHK(rdData[23:0], 24'h000000)
    $display("register test done");
  endtask : tRegs

  task automatic tStores;
    logic [23:0] val [3] = '{24'h000003, 24'h000007, 24'h000005};
    logic [7:0]  adr [3] = '{8'h10, 8'h14, 8'h0C};
    for (int s = 0; s < 3; s++)
    begin
      setting <= val[s];
      apb(8'h00, 1'b1, B | (32'(s + 1) << 7));
      scan(6);
      apb(8'h00, 1'b1, B);
    end
    setting <= 24'h999999;
    scan(6);
    for (int s = 0; s < 3; s++)
    begin
      apb(adr[s], 1'b0, 32'h0);
      `CHK(rdData[23:0], val[s])
    end
    $display("store test done");
  endtask : tStores

  task automatic tCount;
    logic [11:0] c [7] = '{12'h609, 12'h601, 12'h001, 12'h201, 12'h600, 12'h602, 12'h600};
    int          p [7] = '{3, 12, 10, 12, 3, 4, 13};
    logic [23:0] e [7] = '{24'h0, 24'h12, 24'h14, 24'h16, 24'h13, 24'h13, 24'h0};
    for (int i = 0; i < 7; i++)
    begin
      apb(8'h00, 1'b1, B | {20'h0, c[i]});
      cnt(p[i]);
      apb(8'h04, 1'b0, 32'h0);
      `CHK(rdData[23:0], e[i])
    end
    cyc(250);
    apb(8'h04, 1'b0, 32'h0);
    `CHK(rdData[23:0], 24'h000000)
    `CHK(zeroFlag, 1'b1)
    $display("count test done");
  endtask : tCount

  task automatic tAuto;
    apb(8'h00, 1'b1, B | 32'h609);
    apb(8'h00, 1'b1, B | 32'h601);
    cnt(3);
    `CHK(preFlag, 1'b1)
    cnt(4);
    `CHK(preFlag, 1'b0)
    cyc(400);
    `CHK(mainFlag, 1'b1)
    cnt(1);
    `CHK(mainFlag, 1'b0)
    apb(8'h00, 1'b1, 32'h64D);
    apb(8'h00, 1'b1, 32'h645);
    cnt(7);
    cyc(100);
    `CHK(mainFlag, 1'b1)
    cyc(230);
    `CHK(mainFlag, 1'b0)
    apb(8'h04, 1'b0, 32'h0);
    `CHK(rdData[23:0], 24'h000000)
    apb(8'h00, 1'b1, B | 32'h628);
    apb(8'h04, 1'b0, 32'h0);
    `CHK(rdData[23:0], 24'h000000)
    apb(8'h00, 1'b1, B | 32'h620);
    apb(8'h04, 1'b0, 32'h0);
    `CHK(rdData[23:0], 24'h000005)
    apb(8'h00, 1'b1, 32'h614);
    cnt(5);
    `CHK(zeroFlag, 1'b1)
    cyc(200);
    apb(8'h04, 1'b0, 32'h0);
    `CHK(rdData[23:0], 24'h000005)
    `CHK(zeroFlag, 1'b0)
    $display("automatic test done");
  endtask : tAuto

  task automatic tLatch;
    apb(8'h00, 1'b1, 32'h650);
    cnt(2);
    apb(8'h18, 1'b0, 32'h0);
    `CHK(rdData[23:0], 24'h000005)
    apb(8'h00, 1'b1, 32'h654);
    apb(8'h18, 1'b0, 32'h0);
    `CHK(rdData[23:0], 24'h000003)
    $display("latch test done");
  endtask : tLatch

  task automatic tDisplay;
    for (int n = 0; n < 6 && digitSel !== 6'h20; n++)
      scan(1);
    `CHK(segOut, 7'h00)
    scan(5);
    `CHK(digitSel, 6'h01)
    `CHK(bcdOut, 4'h3)
    `CHK(segOut, 7'h4F)
    unblankMask <= 6'h20;
    scan(1);
    `CHK(segOut, 7'h3F)
    unblankMask <= 6'h00;
    apb(8'h00, 1'b1, 32'hE54);
    cyc(2);
    `CHK(segOut, 7'h7F)
    `CHK(bcdOut, 4'h0)
    apb(8'h00, 1'b1, 32'h654);
    $display("display test done");
  endtask : tDisplay

  task automatic printVerdict;
    $display("checks %0d, mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : printVerdict

  initial
  begin
    cyc(4);
    rst <= 1'b0;
    tRegs();
    tStores();
    tCount();
    tAuto();
    tLatch();
    tDisplay();
    printVerdict();
  end
endmodule : pdc_counter_tb_top
`default_nettype wire

// file: verification/pdc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_panel_model (
  input  wire logic [5:0]  digitSel,    // row drive from counter
  input  wire logic [23:0] setting,     // switch digits, msd on top
  input  wire logic [5:0]  unblankMask, // selects wired to override
  output logic      [3:0]  bcdIn,       // switch common lines
  output logic             unblank      // override pin
);
  always_comb
  begin
    bcdIn = 4'h0; // pull-downs when no row is driven
    for (int i = 0; i < 6; i++)
      if (digitSel[i])
        bcdIn = setting[4*i +: 4];
  end
  assign unblank = |(digitSel & unblankMask);
endmodule : pdc_panel_model
`default_nettype wire

// file: verilog/pdc_counter.sv
// Overview of operation
// - count changes only on rising count input edges after prescale division.
// - direction high counts up, low counts down.
// - count inhibit high ignores count edges and holds the value.
// - data transfer high makes output latches follow the live count.
// - data transfer low freezes the latched display and bcd outputs.
// - reset high forces and holds all decades at zero.
// - up mode match with main store returns count to zero unless inhibited.
// - preset high loads the counter from the preset store.
// - down mode reaching zero loads the preset store unless inhibited.
// - store select 00 none, 01 presignal, 10 main, 11 preset.
// - bcd input loads the selected store one decade per digit select.
// - divide control 00 divides by 5, 01 by 6, 11 by 1.
// - main flag high on main match; 2.5 us pulse in automatic up mode.
// - with auto reset inhibited, main flag stays until next count or reset.
// - presignal flag high on presignal match until next count, reset or preset.
// - zero flag high at zero; short pulse during automatic down reload.
// - with auto preset inhibited, zero holds until preset or count edge.
// - six one-hot digit selects step from MSD to LSD on scan clock.
// - leading zeros blanked on segments, least significant digit always shown.
// - blanking override high during a digit period unblanks that digit.
// - lamp test lights all segments, bcd outputs unaffected.
// - bcd output is stable while the digit select is high; segments follow one clock after the select edge.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"

module pdc_counter
  import pdc_pkg::*;
(
  input  wire logic        ref_clk,  // system clock
  input  wire logic        rst,      // async reset, active high
  input  wire logic        countIn,  // count input pin
  input  wire logic        scanClk,  // scan clock pin
  input  wire logic [3:0]  bcdIn,    // thumbwheel bcd data
  input  wire logic        unblank,  // blanking override pin
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  output logic             mainFlag, // main signal match
  output logic             preFlag,  // presignal match
  output logic             zeroFlag, // count at zero
  output logic      [5:0]  digitSel, // one-hot digit select, bit 5 = MSD
  output logic      [3:0]  bcdOut,   // multiplexed bcd digit
  output logic      [6:0]  segOut    // multiplexed segments
);

  localparam logic [`PDC_TMR_W-1:0] MAIN_HOLD = `PDC_TMR_W'(`PDC_MAIN_PULSE_CYC - 1);
  localparam logic [`PDC_TMR_W-1:0] ZERO_HOLD = `PDC_TMR_W'(`PDC_ZERO_PULSE_CYC - 1);

  function automatic logic [3:0] getDigit(input logic [`PDC_CNT_W-1:0] v, input logic [2:0] idx);
    logic [3:0] d;
    d = `PDC_DIGIT_ZERO;
    for (int i = 0; i < `PDC_DECADES; i++)
      if (idx == 3'(i))
        d = v[i*4 +: 4];
    return d;
  endfunction : getDigit

  function automatic logic [`PDC_CNT_W-1:0] setDigit(input logic [`PDC_CNT_W-1:0] v, input logic [2:0] idx,
                                                     input logic [3:0] d);
    logic [`PDC_CNT_W-1:0] r;
    r = v;
    for (int i = 0; i < `PDC_DECADES; i++)
      if (idx == 3'(i))
        r[i*4 +: 4] = d;
    return r;
  endfunction : setDigit

  function automatic logic [`PDC_CNT_W-1:0] bcdInc(input logic [`PDC_CNT_W-1:0] v);
    logic [`PDC_CNT_W-1:0] r;
    logic                  carry;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < `PDC_DECADES; i++)
      if (carry)
      begin
        carry = (v[i*4 +: 4] >= `PDC_DIGIT_MAX);
        r[i*4 +: 4] = carry ? `PDC_DIGIT_ZERO : v[i*4 +: 4] + 4'h1;
      end
    return r;
  endfunction : bcdInc

  function automatic logic [`PDC_CNT_W-1:0] bcdDec(input logic [`PDC_CNT_W-1:0] v);
    logic [`PDC_CNT_W-1:0] r;
    logic                  borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < `PDC_DECADES; i++)
      if (borrow)
      begin
        borrow = (v[i*4 +: 4] == `PDC_DIGIT_ZERO);
        r[i*4 +: 4] = borrow ? `PDC_DIGIT_MAX : v[i*4 +: 4] - 4'h1;
      end
    return r;
  endfunction : bcdDec

  function automatic logic [2:0] divLast(input logic [1:0] sel);
    logic [2:0] r;
    unique case (sel)
      `PDC_DIVSEL_5: r = `PDC_DIV5_LAST;
      `PDC_DIVSEL_6: r = `PDC_DIV6_LAST;
      default:       r = `PDC_DIV1_LAST;
    endcase
    return r;
  endfunction : divLast

  function automatic logic [2:0] scanIndex(input pdc_scan_t s);
    logic [2:0] r;
    unique case (s)
      PDC_SCAN_D5: r = 3'h5;
      PDC_SCAN_D4: r = 3'h4;
      PDC_SCAN_D3: r = 3'h3;
      PDC_SCAN_D2: r = 3'h2;
      PDC_SCAN_D1: r = 3'h1;
      PDC_SCAN_D0: r = 3'h0;
      default:     r = `PDC_MSD_IDX;
    endcase
    return r;
  endfunction : scanIndex

  function automatic pdc_scan_t nextScan(input pdc_scan_t s);
    pdc_scan_t r;
    unique case (s)
      PDC_SCAN_D5: r = PDC_SCAN_D4;
      PDC_SCAN_D4: r = PDC_SCAN_D3;
      PDC_SCAN_D3: r = PDC_SCAN_D2;
      PDC_SCAN_D2: r = PDC_SCAN_D1;
      PDC_SCAN_D1: r = PDC_SCAN_D0;
      PDC_SCAN_D0: r = PDC_SCAN_D5;
      default:     r = PDC_SCAN_D5;
    endcase
    return r;
  endfunction : nextScan

  // true when every digit from idx up to the MSD is zero and idx is not the LSD
  function automatic logic leadZero(input logic [`PDC_CNT_W-1:0] v, input logic [2:0] idx);
    logic nz;
    nz = 1'b0;
    for (int i = 0; i < `PDC_DECADES; i++)
      if (3'(i) >= idx && v[i*4 +: 4] != `PDC_DIGIT_ZERO)
        nz = 1'b1;
    return !nz && idx != `PDC_LSD_IDX;
  endfunction : leadZero

  logic [`PDC_CTRL_W-1:0] ctrl;
  logic [`PDC_CNT_W-1:0]  count;
  logic [`PDC_CNT_W-1:0]  latchVal;
  logic [`PDC_CNT_W-1:0]  presetStore;
  logic [`PDC_CNT_W-1:0]  presigStore;
  logic [`PDC_CNT_W-1:0]  mainStore;
  logic [`PDC_TMR_W-1:0]  holdTimer;
  logic [2:0]             prescale;
  logic [2:0]             selIdx;
  logic                   countPrev;
  logic                   scanPrev;
  logic                   blankLz;
  pdc_cnt_state_t         cntState;
  pdc_scan_t              scanState;
  pdc_scan_t              next_scanState;
  pdc_store_sel_t         storeSel;
  logic [6:0]             segRaw;

  wire logic       upMode     = ctrl[`PDC_B_UP];
  wire logic       inhibit    = ctrl[`PDC_B_INHIBIT];
  wire logic       xfer       = ctrl[`PDC_B_XFER];
  wire logic       cntReset   = ctrl[`PDC_B_RESET];
  wire logic       noAutoRst  = ctrl[`PDC_B_NO_AUTO_RST];
  wire logic       presetReq  = ctrl[`PDC_B_PRESET];
  wire logic       noAutoPre  = ctrl[`PDC_B_NO_AUTO_PRE];
  wire logic       lampTest   = ctrl[`PDC_B_LAMP];
  wire logic [1:0] divSel     = ctrl[`PDC_F_DIV_HI:`PDC_F_DIV_LO];
  wire logic       countEdge  = countIn && !countPrev;
  wire logic       scanEdge   = scanClk && !scanPrev;
  wire logic       presDone   = prescale >= divLast(divSel);
  wire logic       countTick  = countEdge && presDone;
  wire logic       apbWrite   = psel && penable && pwrite;

  assign storeSel = pdc_store_sel_t'(ctrl[`PDC_F_STORE_HI:`PDC_F_STORE_LO]);
  assign pready   = 1'b1;

  // control register, the only software-written state
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ctrl <= `PDC_CTRL_RST;
    else if (apbWrite && paddr == `PDC_OFF_CTRL)
      ctrl <= pwdata[`PDC_CTRL_W-1:0];
  end

  always_comb
  begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    unique case (paddr)
      `PDC_OFF_CTRL:   prdata[`PDC_CTRL_W-1:0] = ctrl;
      `PDC_OFF_COUNT:  prdata[`PDC_CNT_W-1:0] = count;
      `PDC_OFF_FLAGS:
      begin
        prdata[`PDC_FL_MAIN] = mainFlag;
        prdata[`PDC_FL_PRE]  = preFlag;
        prdata[`PDC_FL_ZERO] = zeroFlag;
        prdata[`PDC_FL_DSEL_HI:`PDC_FL_DSEL_LO]   = digitSel;
        prdata[`PDC_FL_STATE_HI:`PDC_FL_STATE_LO] = cntState;
      end
      `PDC_OFF_PRESET: prdata[`PDC_CNT_W-1:0] = presetStore;
      `PDC_OFF_PRESIG: prdata[`PDC_CNT_W-1:0] = presigStore;
      `PDC_OFF_MAIN:   prdata[`PDC_CNT_W-1:0] = mainStore;
      `PDC_OFF_LATCH:  prdata[`PDC_CNT_W-1:0] = latchVal;
      default:         pslverr = psel && penable;
    endcase
  end

  // edge detectors on the pins, sampled as synchronous inputs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      countPrev <= 1'b0;
      scanPrev  <= 1'b0;
    end
    else
    begin
      countPrev <= countIn;
      scanPrev  <= scanClk;
    end
  end

  // prescaler keeps running under inhibit so the phase is not lost
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prescale <= 3'h0;
    else if (countEdge)
      prescale <= presDone ? 3'h0 : prescale + 3'h1;
  end

  // counter state machine; auto actions hold the flag for the pulse time first
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      count     <= `PDC_COUNT_ZERO;
      cntState  <= PDC_RUN;
      holdTimer <= '0;
    end
    else if (cntReset)
    begin
      count    <= `PDC_COUNT_ZERO;
      cntState <= PDC_RUN;
    end
    else if (presetReq)
    begin
      count    <= presetStore;
      cntState <= PDC_RUN;
    end
    else
    begin
      unique case (cntState)
        PDC_RUN:
          if (upMode && !noAutoRst && count == mainStore)
          begin
            cntState  <= PDC_HOLD_RST;
            holdTimer <= MAIN_HOLD;
          end
          else if (!upMode && !noAutoPre && count == `PDC_COUNT_ZERO)
          begin
            cntState  <= PDC_HOLD_PRE;
            holdTimer <= ZERO_HOLD;
          end
          else if (countTick && !inhibit)
            count <= upMode ? bcdInc(count) : bcdDec(count);
        PDC_HOLD_RST:
          if (holdTimer == '0)
          begin
            count    <= `PDC_COUNT_ZERO;
            cntState <= PDC_RUN;
          end
          else
            holdTimer <= holdTimer - `PDC_TMR_W'(1);
        PDC_HOLD_PRE:
          if (holdTimer == '0)
          begin
            count    <= presetStore;
            cntState <= PDC_RUN;
          end
          else
            holdTimer <= holdTimer - `PDC_TMR_W'(1);
        default:
          cntState <= PDC_RUN;
      endcase
    end
  end

  // comparator flags follow the count, so they fall on the next count, reset or preset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mainFlag <= 1'b0;
      preFlag  <= 1'b0;
      zeroFlag <= 1'b0;
    end
    else
    begin
      mainFlag <= count == mainStore;
      preFlag  <= count == presigStore;
      zeroFlag <= count == `PDC_COUNT_ZERO;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      latchVal <= `PDC_COUNT_ZERO;
    else if (xfer)
      latchVal <= count;
  end

  // thumbwheel loading uses the decade whose select is currently on the pins
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      presetStore <= `PDC_COUNT_ZERO;
      presigStore <= `PDC_COUNT_ZERO;
      mainStore   <= `PDC_COUNT_ZERO;
    end
    else
    begin
      unique case (storeSel)
        PDC_SEL_NONE:   ;
        PDC_SEL_PRESIG: presigStore <= setDigit(presigStore, selIdx, bcdIn);
        PDC_SEL_MAIN:   mainStore   <= setDigit(mainStore, selIdx, bcdIn);
        PDC_SEL_PRESET: presetStore <= setDigit(presetStore, selIdx, bcdIn);
      endcase
    end
  end

  assign next_scanState = nextScan(scanState);

  // digit data is captured with the select, so it cannot move mid-period
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scanState <= PDC_SCAN_D5;
      selIdx    <= `PDC_MSD_IDX;
      digitSel  <= `PDC_DSEL_MSD;
      bcdOut    <= `PDC_DIGIT_ZERO;
      blankLz   <= 1'b1;
    end
    else if (scanEdge)
    begin
      scanState <= next_scanState;
      selIdx    <= scanIndex(next_scanState);
      digitSel  <= `PDC_DSEL_LSD << scanIndex(next_scanState);
      bcdOut    <= getDigit(latchVal, scanIndex(next_scanState));
      blankLz   <= leadZero(latchVal, scanIndex(next_scanState));
    end
  end

  pdc_seg7 u_seg7 (
    .digit    (bcdOut),
    .blank    (blankLz && !unblank),
    .lampTest (lampTest),
    .seg      (segRaw)
  );

  // one cycle behind the select edge; override pin is usually a select line itself
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      segOut <= `PDC_SEG_OFF;
    else
      segOut <= segRaw;
  end

endmodule : pdc_counter
`default_nettype wire

// file: verilog/pdc_seg7.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"

module pdc_seg7 (
  input  wire logic [3:0] digit,    // bcd digit
  input  wire logic       blank,    // suppress this digit
  input  wire logic       lampTest, // light all segments
  output logic      [6:0] seg       // segments a..g in bits 0..6
);

  logic [6:0] pattern;

  always_comb
  begin
    unique case (digit)
      4'h0: pattern = 7'h3F;
      4'h1: pattern = 7'h06;
      4'h2: pattern = 7'h5B;
      4'h3: pattern = 7'h4F;
      4'h4: pattern = 7'h66;
      4'h5: pattern = 7'h6D;
      4'h6: pattern = 7'h7D;
      4'h7: pattern = 7'h07;
      4'h8: pattern = 7'h7F;
      4'h9: pattern = 7'h6F;
      default: pattern = `PDC_SEG_OFF;
    endcase
  end

  always_comb
  begin
    if (lampTest)
      seg = `PDC_SEG_ALL;
    else if (blank)
      seg = `PDC_SEG_OFF;
    else
      seg = pattern;
  end

endmodule : pdc_seg7
`default_nettype wire
